// [logic/fps_div_iter.sv]
// divide iteration counter for sum stage two
module fps_div_iter #(
    parameter int CNT_W = 6
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // start with the number of extra clocks
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] count,
    // high while the divide still iterates
    output logic                  busy
);

    // remaining extra clocks
    logic [CNT_W-1:0] cnt_reg;

    // load on entry, then count down to zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (load) begin
            cnt_reg <= count;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // busy while any extra clock is left
    assign busy = (cnt_reg != '0);

endmodule : fps_div_iter

// [logic/fps_pkg.sv]
// shared types, constants and decode functions for the fpu sequencer
package fps_pkg;

    // register file geometry
    localparam int REG_W = 5;
    localparam int NREG  = 32;

    // divide precision figures (extra clocks in sum stage two are 1 + r)
    localparam logic [5:0] DIV_R_SGL  = 6'h18;
    localparam logic [5:0] DIV_R_INT  = 6'h20;
    localparam logic [5:0] DIV_R_DBL  = 6'h35;
    localparam logic [5:0] DIV_EXTRA  = 6'h01;

    // extra issue-stage clocks for a double-times-double multiply
    localparam logic [1:0] DD_HOLD    = 2'h2;
    localparam logic [1:0] HOLD_LAST  = 2'h1;

    // operation classes, which pick the pipe
    typedef enum logic [2:0] {
        CLS_FADD = 3'b000,
        CLS_FMUL = 3'b001,
        CLS_IMUL = 3'b010,
        CLS_FDIV = 3'b011,
        CLS_IDIV = 3'b100
    } fps_cls_t;

    // issue stage phases
    typedef enum logic [1:0] {
        PH_LO   = 2'b00,
        PH_HI   = 2'b01,
        PH_HOLD = 2'b10,
        PH_WAIT = 2'b11
    } fps_phase_t;

    // which path fed the retire stage
    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_IMUL = 2'b01,
        SRC_FMUL = 2'b10,
        SRC_ADD  = 2'b11
    } fps_src_t;

    // request from the instruction issue unit
    typedef struct packed {
        fps_cls_t         cls;
        logic [REG_W-1:0] src_a;
        logic             a_dbl;
        logic [REG_W-1:0] src_b;
        logic             b_dbl;
        logic [REG_W-1:0] dst;
        logic             dst_dbl;
    } fps_req_t;

    // op tag carried down the pipes
    typedef struct packed {
        fps_cls_t         cls;
        logic [REG_W-1:0] dst;
        logic             dst_dbl;
    } fps_op_t;

    // multiplies go down the product pipe
    function automatic logic is_mul(input fps_cls_t c);
        return (c == CLS_FMUL) || (c == CLS_IMUL);
    endfunction : is_mul

    // divides iterate in sum stage two
    function automatic logic is_div(input fps_cls_t c);
        return (c == CLS_FDIV) || (c == CLS_IDIV);
    endfunction : is_div

    // extra sum-stage-two clocks for a divide
    function automatic logic [5:0] div_clocks(input fps_op_t o);
        if (o.cls == CLS_IDIV) begin
            return DIV_EXTRA + DIV_R_INT;
        end
        return DIV_EXTRA + (o.dst_dbl ? DIV_R_DBL : DIV_R_SGL);
    endfunction : div_clocks

    // upper register of a pair
    function automatic logic [REG_W-1:0] reg_up(input logic [REG_W-1:0] r);
        return r + 5'h01;
    endfunction : reg_up

    // register r falls inside destination d (pair when dbl)
    function automatic logic hits(input logic [REG_W-1:0] r,
                                  input logic [REG_W-1:0] d,
                                  input logic dbl);
        return (r == d) || (dbl && (r == reg_up(d)));
    endfunction : hits

endpackage : fps_pkg

// [logic/fps_scoreboard.sv]
// per-register busy bits; set wins over clear on the same register
module fps_scoreboard #(
    parameter int NREG  = 32,
    parameter int REG_W = 5
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // set a destination (pair when set_dbl)
    input  wire logic             set_en,
    input  wire logic [REG_W-1:0] set_reg,
    input  wire logic             set_dbl,
    // clear one register as its half retires
    input  wire logic             clr_en,
    input  wire logic [REG_W-1:0] clr_reg,
    // busy bits, straight from flops
    output logic [NREG-1:0]       busy
);

    // one flop per register
    for (genvar i = 0; i < NREG; i++) begin : g_bit
        // hit flags for this register
        logic set_hit;
        logic clr_hit;
        assign set_hit = set_en && fps_pkg::hits(REG_W'(i), set_reg, set_dbl);
        assign clr_hit = clr_en && (clr_reg == REG_W'(i));
        // set beats clear so a new owner is never lost
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                busy[i] <= 1'b0;
            end else if (set_hit) begin
                busy[i] <= 1'b1;
            end else if (clr_hit) begin
                busy[i] <= 1'b0;
            end
        end
    end

endmodule : fps_scoreboard

// [logic/fps_sequencer.sv]
// fpu pipeline sequencer: issue stage, product and sum pipes, retire stage
module fps_sequencer (
    // clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    // issue request
    input  wire logic                     req_valid,
    input  wire fps_pkg::fps_req_t        req,
    output logic                          req_ready,
    output logic                          issue_stall,
    // operand fetch and check
    output logic                          rf_rd_en,
    output logic                          rf_rd_hi,
    output logic [fps_pkg::REG_W-1:0]     rf_rd_a,
    output logic [fps_pkg::REG_W-1:0]     rf_rd_b,
    input  wire logic                     opnd_bad,
    output logic                          prec_exc,
    // writeback arbitration and forwarding
    output logic                          wb_waive,
    output logic                          wb_req,
    output logic [fps_pkg::REG_W-1:0]     wb_reg,
    input  wire logic                     wb_gnt,
    output logic                          fwd_valid,
    output logic [fps_pkg::REG_W-1:0]     fwd_reg,
    input  wire logic                     res_exc,
    output logic                          imp_exc,
    // status
    output fps_pkg::fps_src_t             ret_src,
    output logic                          div_busy,
    output logic [fps_pkg::NREG-1:0]      sb_busy
);

    // issue stage state
    logic                iss_v_reg;
    fps_pkg::fps_req_t   iss_reg;
    fps_pkg::fps_phase_t ph_reg;
    logic [1:0]          hold_reg;
    logic                bad_reg;
    // product pipe stages two to four
    logic                m2_v_reg;
    logic                m3_v_reg;
    logic                m4_v_reg;
    fps_pkg::fps_op_t    m2_reg;
    fps_pkg::fps_op_t    m3_reg;
    fps_pkg::fps_op_t    m4_reg;
    // sum pipe stages two to four
    logic                a2_v_reg;
    logic                a3_v_reg;
    logic                a4_v_reg;
    fps_pkg::fps_op_t    a2_reg;
    fps_pkg::fps_op_t    a3_reg;
    fps_pkg::fps_op_t    a4_reg;
    // retire stage
    logic                ret_v_reg;
    fps_pkg::fps_op_t    ret_reg;
    logic                half_reg;
    fps_pkg::fps_src_t   src_reg;
    // registered pulses
    logic                waive_reg;
    logic                prec_reg;
    logic                imp_reg;

    // combinational terms
    logic             any_dbl;
    logic             to_mul;
    logic             need_hold;
    logic             hi_clear;
    logic             fetch_done;
    logic             tgt_free;
    logic             leave;
    logic             dec_ok;
    logic             accept;
    logic             imul_cand;
    logic             g_imul;
    logic             g_fmul;
    logic             g_add;
    logic             ret_free;
    logic             m2_hold;
    logic             m3_hold;
    logic             m4_hold;
    logic             a2_hold;
    logic             a3_hold;
    logic             a4_hold;
    logic             div_load;
    fps_pkg::fps_op_t iss_op;
    fps_pkg::fps_op_t ret_next;

    // tag of the op in the issue stage
    assign iss_op = '{cls: iss_reg.cls, dst: iss_reg.dst, dst_dbl: iss_reg.dst_dbl};

    // routing and fetch shape
    // route by class
    assign to_mul    = fps_pkg::is_mul(iss_reg.cls);
    assign any_dbl   = iss_reg.a_dbl || iss_reg.b_dbl;
    assign need_hold = (iss_reg.cls == fps_pkg::CLS_FMUL) && iss_reg.a_dbl && iss_reg.b_dbl;

    // upper source halves checked together in the second clock
    assign hi_clear = !(iss_reg.a_dbl && sb_busy[fps_pkg::reg_up(iss_reg.src_a)]) &&
                      !(iss_reg.b_dbl && sb_busy[fps_pkg::reg_up(iss_reg.src_b)]);

    // all sources fetched this clock
    // double sources need the second fetch clock
    assign fetch_done = iss_v_reg &&
                        (((ph_reg == fps_pkg::PH_LO) && !any_dbl) ||
                         ((ph_reg == fps_pkg::PH_HI) && hi_clear));

    // target stage two can take the op
    // a held sum stage two keeps a sum op waiting here
    assign tgt_free = to_mul ? (!m2_v_reg || !m2_hold) : (!a2_v_reg || !a2_hold);

    // op moves out of the issue stage this clock
    // a double-double multiply leaves only after the two hold clocks
    assign leave = tgt_free &&
                   ((fetch_done && !need_hold) ||
                    (iss_v_reg && (ph_reg == fps_pkg::PH_HOLD) &&
                     (hold_reg == fps_pkg::HOLD_LAST)) ||
                    (iss_v_reg && (ph_reg == fps_pkg::PH_WAIT)));

    // decode check of lower sources and destinations
    // scoreboard of sources and destinations
    // dependents held until the register they read is forwarded at retire
    assign dec_ok = !sb_busy[req.src_a] && !sb_busy[req.src_b] && !sb_busy[req.dst] &&
                    !(req.dst_dbl && sb_busy[fps_pkg::reg_up(req.dst)]) &&
                    !(iss_v_reg && (fps_pkg::hits(req.src_a, iss_reg.dst, iss_reg.dst_dbl) ||
                                    fps_pkg::hits(req.src_b, iss_reg.dst, iss_reg.dst_dbl) ||
                                    fps_pkg::hits(req.dst, iss_reg.dst, iss_reg.dst_dbl)));

    // handshake with the issue unit
    // a new op enters as the previous one leaves
    // no entry while an op is still fetching
    assign req_ready   = (!iss_v_reg || leave) && dec_ok;
    assign accept      = req_valid && req_ready;
    assign issue_stall = req_valid && !req_ready;

    // operand fetch addresses
    assign rf_rd_en = iss_v_reg && ((ph_reg == fps_pkg::PH_LO) || (ph_reg == fps_pkg::PH_HI));
    assign rf_rd_hi = (ph_reg == fps_pkg::PH_HI);
    assign rf_rd_a  = rf_rd_hi ? fps_pkg::reg_up(iss_reg.src_a) : iss_reg.src_a;
    assign rf_rd_b  = rf_rd_hi ? fps_pkg::reg_up(iss_reg.src_b) : iss_reg.src_b;

    // issue stage capture
    // op enters and fetches once scoreboard is clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            iss_v_reg <= 1'b0;
            iss_reg   <= '0;
        end else if (accept) begin
            iss_v_reg <= 1'b1;
            iss_reg   <= req;
        end else if (leave) begin
            iss_v_reg <= 1'b0;
        end
    end

    // issue stage phase walk
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ph_reg   <= fps_pkg::PH_LO;
            hold_reg <= '0;
        end else if (accept) begin
            ph_reg <= fps_pkg::PH_LO;
        end else if (iss_v_reg && !leave) begin
            unique case (ph_reg)
                // first fetch clock
                fps_pkg::PH_LO: begin
                    if (any_dbl) begin
                        ph_reg <= fps_pkg::PH_HI;
                    end else if (need_hold) begin
                        ph_reg   <= fps_pkg::PH_HOLD;
                        hold_reg <= fps_pkg::DD_HOLD;
                    end else begin
                        ph_reg <= fps_pkg::PH_WAIT;
                    end
                end
                // second fetch clock, repeats while upper halves are busy
                fps_pkg::PH_HI: begin
                    if (hi_clear && need_hold) begin
                        ph_reg   <= fps_pkg::PH_HOLD;
                        hold_reg <= fps_pkg::DD_HOLD;
                    end else if (hi_clear) begin
                        ph_reg <= fps_pkg::PH_WAIT;
                    end
                end
                fps_pkg::PH_HOLD: begin
                    if (hold_reg == fps_pkg::HOLD_LAST) begin
                        ph_reg <= fps_pkg::PH_WAIT;
                    end else begin
                        hold_reg <= hold_reg - 2'h1;
                    end
                end
                // waiting for stage two to free up
                fps_pkg::PH_WAIT: begin
                    ph_reg <= fps_pkg::PH_WAIT;
                end
            endcase
        end
    end

    // operand fault gathering and writeback waiver
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bad_reg   <= 1'b0;
            prec_reg  <= 1'b0;
            waive_reg <= 1'b0;
        end else begin
            bad_reg   <= accept ? 1'b0 : (bad_reg || (rf_rd_en && opnd_bad));
            // precise fault reported as fetching ends
            prec_reg  <= fetch_done && (bad_reg || opnd_bad);
            // slot after the first execute clock is given up
            waive_reg <= iss_v_reg && (ph_reg == fps_pkg::PH_LO);
        end
    end

    // retire arbitration
    // integer multiply, then float multiply, then sum pipe
    // integer multiply leaves from product stage three
    assign imul_cand = m3_v_reg && (m3_reg.cls == fps_pkg::CLS_IMUL);
    assign ret_free  = !ret_v_reg || (wb_gnt && (!ret_reg.dst_dbl || half_reg));
    assign g_imul    = ret_free && imul_cand;
    assign g_fmul    = ret_free && !imul_cand && m4_v_reg;
    assign g_add     = ret_free && !imul_cand && !m4_v_reg && a4_v_reg;
    assign ret_next  = g_imul ? m3_reg : (g_fmul ? m4_reg : a4_reg);

    // stall chains
    // the sum pipe also stalls while product stage three or four wins retire
    assign m4_hold = m4_v_reg && !g_fmul;
    assign m3_hold = m3_v_reg && (imul_cand ? !g_imul : m4_hold);
    assign m2_hold = m2_v_reg && m3_hold;
    assign a4_hold = a4_v_reg && !g_add;
    assign a3_hold = a3_v_reg && a4_hold;
    // iterating divide holds sum stage two only
    assign a2_hold = a2_v_reg && (div_busy || a3_hold);

    // product pipe advance
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            m2_v_reg <= 1'b0;
            m3_v_reg <= 1'b0;
            m4_v_reg <= 1'b0;
            m2_reg   <= '0;
            m3_reg   <= '0;
            m4_reg   <= '0;
        end else begin
            if (!m2_hold) begin
                m2_v_reg <= leave && to_mul;
                m2_reg   <= iss_op;
            end
            if (!m3_hold) begin
                m3_v_reg <= m2_v_reg;
                m3_reg   <= m2_reg;
            end
            // integer multiply never enters stage four
            if (!m4_hold) begin
                m4_v_reg <= m3_v_reg && !imul_cand;
                m4_reg   <= m3_reg;
            end
        end
    end

    // sum pipe advance
    // one clock per sum stage unless held
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            a2_v_reg <= 1'b0;
            a3_v_reg <= 1'b0;
            a4_v_reg <= 1'b0;
            a2_reg   <= '0;
            a3_reg   <= '0;
            a4_reg   <= '0;
        end else begin
            if (!a2_hold) begin
                a2_v_reg <= leave && !to_mul;
                a2_reg   <= iss_op;
            end
            if (!a3_hold) begin
                a3_v_reg <= a2_v_reg && !a2_hold;
                a3_reg   <= a2_reg;
            end
            if (!a4_hold) begin
                a4_v_reg <= a3_v_reg;
                a4_reg   <= a3_reg;
            end
        end
    end

    // divide iteration in sum stage two
    // 1 + R extra clocks after the first
    assign div_load = leave && !to_mul && fps_pkg::is_div(iss_reg.cls);
    fps_div_iter #(
        .CNT_W (6)
    ) u_div (
        .mclk  (mclk),
        .rst_n (rst_n),
        .load  (div_load),
        .count (fps_pkg::div_clocks(iss_op)),
        .busy  (div_busy)
    );

    // retire stage, two passes for a double result
    // second pass writes the upper register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ret_v_reg <= 1'b0;
            ret_reg   <= '0;
            half_reg  <= 1'b0;
            src_reg   <= fps_pkg::SRC_NONE;
        end else if (ret_free) begin
            ret_v_reg <= g_imul || g_fmul || g_add;
            ret_reg   <= ret_next;
            half_reg  <= 1'b0;
            src_reg   <= g_imul ? fps_pkg::SRC_IMUL : (g_fmul ? fps_pkg::SRC_FMUL :
                         (g_add ? fps_pkg::SRC_ADD : fps_pkg::SRC_NONE));
        end else if (ret_v_reg && wb_gnt) begin
            half_reg <= 1'b1;
        end
    end

    // writeback request and forwarding
    // slot requested only when execution is done
    // retire stage bids for the writeback slot
    assign wb_req    = ret_v_reg;
    assign wb_reg    = ret_reg.dst | {{(fps_pkg::REG_W-1){1'b0}}, half_reg};
    // each half forwarded as it is granted
    assign fwd_valid = ret_v_reg && wb_gnt;
    assign fwd_reg   = wb_reg;

    // imprecise fault check at retire
    // flagged on the last pass
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            imp_reg <= 1'b0;
        end else begin
            imp_reg <= fwd_valid && res_exc && (!ret_reg.dst_dbl || half_reg);
        end
    end

    // register busy tracking
    // destinations marked once all sources are fetched
    // each half clears as it is written or forwarded
    fps_scoreboard #(
        .NREG  (fps_pkg::NREG),
        .REG_W (fps_pkg::REG_W)
    ) u_sb (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .set_en  (fetch_done),
        .set_reg (iss_reg.dst),
        .set_dbl (iss_reg.dst_dbl),
        .clr_en  (fwd_valid),
        .clr_reg (fwd_reg),
        .busy    (sb_busy)
    );

    // registered outputs
    assign wb_waive = waive_reg;
    assign prec_exc = prec_reg;
    assign imp_exc  = imp_reg;
    assign ret_src  = src_reg;

endmodule : fps_sequencer

// [verification/fps_sequencer_sva.sv]
// port-level assertion checker for the fpu sequencer
module fps_sequencer_sva (
    // clock and reset
    input wire logic              mclk,
    input wire logic              rst_n,
    // issue and fetch
    input wire logic              req_valid,
    input wire fps_pkg::fps_req_t req,
    input wire logic              req_ready,
    input wire logic              issue_stall,
    input wire logic              rf_rd_en,
    input wire logic              rf_rd_hi,
    input wire logic [4:0]        rf_rd_a,
    input wire logic [4:0]        rf_rd_b,
    input wire logic              prec_exc,
    // retire and scoreboard
    input wire logic              wb_waive,
    input wire logic              wb_req,
    input wire logic [4:0]        wb_reg,
    input wire logic              wb_gnt,
    input wire logic              fwd_valid,
    input wire logic [4:0]        fwd_reg,
    input wire logic              imp_exc,
    input wire logic [31:0]       sb_busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire logic         take = req_valid && req_ready; // request accepted this clock
    fps_pkg::fps_req_t held;                          // last accepted request
    // remember the accepted request
    always_ff @(posedge mclk) begin
        if (take) begin
            held <= req;
        end
    end
    property p_fwd;
        wb_req && wb_gnt |-> fwd_valid && fwd_reg == wb_reg;
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward missing");
    property p_stall;
        req_valid && !req_ready |-> issue_stall;
    endproperty
    a_stall: assert property (p_stall) else $error("stall missing");
    property p_waive;
        take |=> ##1 wb_waive;
    endproperty
    a_waive: assert property (p_waive) else $error("slot not waived");
    property p_fetch;
        take |=> rf_rd_en && !rf_rd_hi && rf_rd_a == held.src_a && rf_rd_b == held.src_b;
    endproperty
    a_fetch: assert property (p_fetch) else $error("bad fetch");
    property p_dbl;
        take && (req.a_dbl || req.b_dbl) |=> !req_ready ##1 rf_rd_hi;
    endproperty
    a_dbl: assert property (p_dbl) else $error("no upper fetch");
    property p_sbset;
        take && !req.a_dbl && !req.b_dbl |=> !sb_busy[held.dst] ##1 sb_busy[$past(held.dst)];
    endproperty
    a_sbset: assert property (p_sbset) else $error("busy bit timing");
    property p_prec;
        prec_exc |-> $past(rf_rd_en);
    endproperty
    a_prec: assert property (p_prec) else $error("stray precise");
    property p_imp;
        imp_exc |-> $past(fwd_valid);
    endproperty
    a_imp: assert property (p_imp) else $error("stray imprecise");
    property p_clr;
        fwd_valid |=> !sb_busy[$past(fwd_reg)];
    endproperty
    a_clr: assert property (p_clr) else $error("busy not cleared");
    c_fwd: cover property (fwd_valid);
    c_prec: cover property (prec_exc);
    c_imp: cover property (imp_exc);
endmodule : fps_sequencer_sva
bind fps_sequencer fps_sequencer_sva u_sva (.mclk(mclk), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .issue_stall(issue_stall),
    .rf_rd_en(rf_rd_en), .rf_rd_hi(rf_rd_hi), .rf_rd_a(rf_rd_a), .prec_exc(prec_exc),
    .wb_waive(wb_waive), .wb_req(wb_req), .wb_reg(wb_reg), .wb_gnt(wb_gnt), .rf_rd_b(rf_rd_b),
    .fwd_valid(fwd_valid), .fwd_reg(fwd_reg), .imp_exc(imp_exc), .sb_busy(sb_busy));

// [verification/fps_sequencer_tb.sv]
// self-checking bench for the fpu pipeline sequencer
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin errors++; \
    $display("Error %s expected %0h seen %0h", n, e, a); end end
module fps_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_n, req_valid, req_ready, issue_stall, rf_rd_en, rf_rd_hi, opnd_bad;
    logic prec_exc, wb_waive, wb_req, wb_gnt, fwd_valid, res_exc, imp_exc, div_busy, slow;
    logic [4:0] rf_rd_a, rf_rd_b, wb_reg, fwd_reg;
    logic [31:0] sb_busy;
    fps_pkg::fps_req_t req;
    fps_pkg::fps_src_t ret_src;
    int errors, comparisons, cyc, t0;
    fps_sequencer u_dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .issue_stall(issue_stall), .rf_rd_en(rf_rd_en),
        .rf_rd_hi(rf_rd_hi), .rf_rd_a(rf_rd_a), .rf_rd_b(rf_rd_b), .opnd_bad(opnd_bad),
        .prec_exc(prec_exc), .wb_waive(wb_waive), .wb_req(wb_req), .wb_reg(wb_reg),
        .wb_gnt(wb_gnt), .fwd_valid(fwd_valid), .fwd_reg(fwd_reg), .res_exc(res_exc),
        .imp_exc(imp_exc), .ret_src(ret_src), .div_busy(div_busy), .sb_busy(sb_busy));
    fps_wb_arb u_arb (.mclk(mclk), .rst_n(rst_n), .wb_req(wb_req), .slow(slow),
        .wb_gnt(wb_gnt));
    // clock and cycle count
    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;
    // build a request; d packs a, b and destination double flags
    function automatic fps_pkg::fps_req_t mk(fps_pkg::fps_cls_t c, logic [4:0] a, b, t,
                                             logic [2:0] d);
        return '{c, a, d[2], b, d[1], t, d[0]};
    endfunction : mk
    // offer a request and hold it until taken
    task automatic issue(input fps_pkg::fps_req_t r);
        req_valid <= 1'h1;
        req <= r;
        do @(negedge mclk); while (req_ready !== 1'h1);
        t0 = cyc;
        @(posedge mclk);
    endtask : issue
    // wait for a forwarded register
    task automatic wait_fwd(input logic [4:0] r, output int t);
        do @(negedge mclk); while (!(fwd_valid === 1'h1 && fwd_reg === r));
        t = cyc;
    endtask : wait_fwd
    // issue spacing: single, double, double-double
    task automatic t_rate;
        int s;
        issue(mk(fps_pkg::CLS_FADD, 5'h01, 5'h02, 5'h03, 3'h0));
        s = t0;
        issue(mk(fps_pkg::CLS_FADD, 5'h01, 5'h02, 5'h05, 3'h0));
        issue(mk(fps_pkg::CLS_FADD, 5'h01, 5'h02, 5'h07, 3'h0));
        `CHK("single rate", 2, t0 - s)
        issue(mk(fps_pkg::CLS_FADD, 5'h08, 5'h02, 5'h0A, 3'h4));
        s = t0;
        issue(mk(fps_pkg::CLS_FADD, 5'h01, 5'h02, 5'h0B, 3'h0));
        `CHK("double source", 2, t0 - s)
        issue(mk(fps_pkg::CLS_FMUL, 5'h0C, 5'h0E, 5'h10, 3'h7));
        s = t0;
        issue(mk(fps_pkg::CLS_FADD, 5'h01, 5'h02, 5'h12, 3'h0));
        `CHK("dd multiply", 4, t0 - s)
        req_valid <= 1'h0;
        repeat (14) @(posedge mclk);
        $display("test rate done");
    endtask : t_rate
    // latency per class, divides and a double result
    task automatic t_lat;
        fps_pkg::fps_cls_t c[6] = '{fps_pkg::CLS_FADD, fps_pkg::CLS_IMUL, fps_pkg::CLS_FMUL,
            fps_pkg::CLS_IDIV, fps_pkg::CLS_FDIV, fps_pkg::CLS_FDIV};
        int e[6] = '{5, 4, 5, 38, 30, 59};
        int t;
        for (int i = 0; i < 6; i++) begin
            issue(mk(c[i], 5'h01, 5'h02, 5'h14, {2'h0, i == 5}));
            req_valid <= 1'h0;
            repeat (2) @(negedge mclk);
            `CHK("div busy", i > 2, div_busy)
            wait_fwd(5'h14, t);
            `CHK("latency", e[i], t - t0)
            if (i == 5) begin
                wait_fwd(5'h15, t);
                `CHK("second half", 60, t - t0)
            end
            repeat (2) @(posedge mclk);
        end
        $display("test latency done");
    endtask : t_lat
    // dependent op waits, then retire priority
    task automatic t_dep;
        int s, t;
        issue(mk(fps_pkg::CLS_FADD, 5'h01, 5'h02, 5'h16, 3'h0));
        s = t0;
        issue(mk(fps_pkg::CLS_FMUL, 5'h16, 5'h02, 5'h17, 3'h0));
        `CHK("dependent wait", 6, t0 - s)
        issue(mk(fps_pkg::CLS_FMUL, 5'h01, 5'h02, 5'h18, 3'h0));
        s = t0;
        issue(mk(fps_pkg::CLS_IMUL, 5'h01, 5'h02, 5'h19, 3'h0));
        req_valid <= 1'h0;
        wait_fwd(5'h19, t);
        `CHK("imul first", 5, t - s)
        `CHK("imul path", fps_pkg::SRC_IMUL, ret_src)
        wait_fwd(5'h18, t);
        `CHK("fmul next", 6, t - s)
        repeat (4) @(posedge mclk);
        $display("test dependency done");
    endtask : t_dep
    // operand and result faults with a slow writeback side
    task automatic t_exc;
        int t;
        slow <= 1'h1;
        issue(mk(fps_pkg::CLS_FADD, 5'h01, 5'h02, 5'h1A, 3'h0));
        req_valid <= 1'h0;
        opnd_bad <= 1'h1;
        @(posedge mclk);
        opnd_bad <= 1'h0;
        res_exc <= 1'h1;
        @(negedge mclk);
        `CHK("precise", 1'h1, prec_exc)
        wait_fwd(5'h1A, t);
        @(negedge mclk);
        `CHK("imprecise", 1'h1, imp_exc)
        @(posedge mclk);
        res_exc <= 1'h0;
        slow <= 1'h0;
        $display("test exceptions done");
    endtask : t_exc
    // verdict
    task automatic tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // watchdog
    initial begin
        #20000;
        errors++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        {rst_n, req_valid, opnd_bad, res_exc, slow} = 5'h00;
        req = '0;
        {cyc, errors, comparisons} = '0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'h1;
        @(posedge mclk);
        `CHK("scoreboard idle", 32'h0, sb_busy)
        t_rate();
        t_lat();
        t_dep();
        t_exc();
        tally_and_finish();
    end
endmodule : fps_sequencer_tb

// [verification/fps_wb_arb.sv]
// writeback arbiter model for the register file side
module fps_wb_arb (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // slot request and mode
    input wire logic wb_req,
    input wire logic slow,
    output logic     wb_gnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hold_reg; // high on clocks another unit owns the slot
    // alternate slot owner
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hold_reg <= 1'h0;
        end else begin
            hold_reg <= ~hold_reg;
        end
    end
    // grant unless slow mode gives the slot away
    always_comb wb_gnt = wb_req && !(slow && hold_reg);
endmodule : fps_wb_arb
